//--- bench/internal_osc_freq_select_tb.sv
// Self-checking bench of the oscillator select block.
// Drives the Wishbone port and power events itself; oscillators ready.
`timescale 1ns/1ps
module internal_osc_freq_select_tb;
	import osc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, slp = 1'b0, wake = 1'b0;
	logic [ADR_W-1:0] adr = '0;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, bdat;
	logic ack, pw_s, pw_i;
	logic [1:0] system_clock_select, wdt, fscm;
	int_cfg_s cfg;
	int_cfg_s exp0 [3];
	int n_errors = 0, check_count = 0;
	always #50 clk = ~clk;
	osc_ctrl dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .i_WB_CYC(cyc),
		.i_WB_STB(stb), .i_WB_WE(we), .i_WB_ADR(adr), .i_WB_SEL(sel),
		.i_WB_DAT(wdat), .o_WB_ACK(ack), .o_WB_DAT(bdat),
		.i_LF_READY(1'b1), .i_MF_READY(1'b1), .i_HF_READY(1'b1),
		.i_SLEEP_EXEC(slp), .i_WAKE(wake), .o_SYS_CLK_SEL(system_clock_select),
		.o_INT_CFG(cfg), .o_WDT_CLK_SRC(wdt), .o_FSCM_CLK_SRC(fscm),
		.o_PWR_SLEEP(pw_s), .o_PWR_IDLE(pw_i));
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk_val(input logic [31:0] got, input logic [31:0] e);
		check_count++;
		if (got !== e) begin
			n_errors++;
			$display("Error at %0t: got %h exp %h", $time, got, e);
		end
	endtask
	task automatic chk_cfg(input int_cfg_s got, input int_cfg_s e);
		check_count++;
		if (got !== e) begin
			n_errors++;
			$display("Error at %0t: cfg %h exp %h", $time, got, e);
		end
	endtask
	task automatic bus(input logic w, input logic [ADR_W-1:0] a,
		input logic [7:0] d, input logic [3:0] s);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		chk_val({31'h0, ack}, 32'h1);
		rdat = bdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [ADR_W-1:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask
	task automatic rd(input logic [ADR_W-1:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 4'h0);
		chk_val(rdat, {24'h0, e});
	endtask
	task automatic pwr(input logic idle);
		slp <= 1'b1;
		@(posedge clk);
		slp <= 1'b0;
		@(posedge clk);
		chk_val({30'h0, pw_s, pw_i}, {30'h0, !idle, idle});
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		@(posedge clk);
		chk_val({30'h0, pw_s, pw_i}, 32'h0);
	endtask
	task automatic chk_reset(input logic [7:0] e_ctrl);
		chk_cfg(cfg, {SRC_HF, PS_DIV16, 6'h00});
		chk_val({28'h0, system_clock_select, wdt}, 32'h0);
		rd(ADR_CTRL, e_ctrl);
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		end_of_test;
	end
	initial begin
		exp0[0] = {SRC_LF, PS_DIV1, 6'h00};
		exp0[1] = {SRC_MF, PS_DIV16, 6'h2a};
		exp0[2] = {SRC_HF, PS_DIV512, 6'h2a};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		chk_reset(8'h34);
		rd(ADR_CTRL2, 8'h03);
		rd(ADR_TUNING, 8'h00);
		for (int c = 1; c < 8; c++) begin
			wr(ADR_CTRL, {1'b0, c[2:0], 4'h2});
			chk_cfg(cfg, {c >= 3 ? SRC_HF : SRC_MF,
				4'(c >= 3 ? 7 - c : 2 - c), 6'h00});
		end
		rd(ADR_CTRL, 8'h7e);
		for (int k = 0; k < 3; k++) begin
			wr(ADR_TUNING, k == 0 ? 8'h2a : 8'haa);
			wr(ADR_CTRL2, k == 1 ? 8'h10 : 8'h00);
			wr(ADR_CTRL, 8'h02);
			chk_cfg(cfg, exp0[k]);
			chk_val({28'h0, wdt, fscm}, 32'h0);
		end
		wr(ADR_TUNING, 8'hff);
		chk_cfg(cfg, {SRC_HF, PS_DIV512, 6'h3f});
		rd(ADR_TUNING, 8'hbf);
		for (int s = 0; s < 4; s++) begin
			wr(ADR_CTRL, {6'h0c, s[1:0]});
			chk_val({30'h0, system_clock_select}, 32'(s));
		end
		bus(1'b1, ADR_CTRL, 8'h80, 4'h0);
		rd(ADR_CTRL, 8'h3f);
		wr('0, 8'hff);
		rd('0, 8'h00);
		wr(ADR_CTRL, 8'h30);
		pwr(1'b0);
		wr(ADR_CTRL, 8'hb0);
		pwr(1'b1);
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		// HF ready is still inside its synchroniser two edges after reset
		chk_reset(8'h30);
		end_of_test;
	end
endmodule

//--- bench/osc_ctrl_props.sv
// Port checker of the oscillator select block.
// Bound to osc_ctrl; one clock, synchronous active-high reset.
`timescale 1ns/1ps
module osc_ctrl_props
	import osc_pkg::*;
(
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_SYS_RST,
	// Wishbone
	input wire logic i_WB_CYC,
	input wire logic i_WB_STB,
	input wire logic i_WB_WE,
	input wire logic [ADR_W-1:0] i_WB_ADR,
	input wire logic [3:0] i_WB_SEL,
	input wire logic [31:0] i_WB_DAT,
	input wire logic o_WB_ACK,
	input wire logic [31:0] o_WB_DAT,
	// Power events and clock outputs
	input wire logic i_SLEEP_EXEC,
	input wire logic i_WAKE,
	input wire logic [1:0] o_SYS_CLK_SEL,
	input wire int_cfg_s o_INT_CFG,
	input wire logic [1:0] o_WDT_CLK_SRC,
	input wire logic [1:0] o_FSCM_CLK_SRC,
	input wire logic o_PWR_SLEEP,
	input wire logic o_PWR_IDLE
);
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_SYS_RST);
	logic req;
	logic wr_ctrl;
	assign req = i_WB_CYC && i_WB_STB && !o_WB_ACK;
	assign wr_ctrl = req && i_WB_WE && i_WB_SEL[0] && i_WB_ADR == ADR_CTRL;
	property p_ack; req |=> o_WB_ACK; endproperty
	property p_ack_pulse; o_WB_ACK |=> !o_WB_ACK; endproperty
	property p_dat_idle; !o_WB_ACK |-> o_WB_DAT == 32'h0; endproperty
	property p_fsel;
		wr_ctrl && i_WB_DAT[6:4] == FSEL_16M |=>
		o_INT_CFG.src == SRC_HF && o_INT_CFG.postscale == PS_DIV1;
	endproperty
	property p_scs; wr_ctrl |=> o_SYS_CLK_SEL == $past(i_WB_DAT[1:0]);
	endproperty
	property p_rst_cfg;
		$past(I_SYS_RST) |-> o_INT_CFG == {SRC_HF, PS_DIV16, 6'h00};
	endproperty
	property p_rst_scs; $past(I_SYS_RST) |-> o_SYS_CLK_SEL == 2'h0;
	endproperty
	property p_lf; o_WDT_CLK_SRC == SRC_LF && o_FSCM_CLK_SRC == SRC_LF;
	endproperty
	property p_sleep;
		i_SLEEP_EXEC && !i_WAKE && !o_PWR_SLEEP && !o_PWR_IDLE |=>
		o_PWR_SLEEP != o_PWR_IDLE;
	endproperty
	property p_lf_tune;
		o_INT_CFG.src == SRC_LF |->
		o_INT_CFG.tune == 6'h00 && o_INT_CFG.postscale == PS_DIV1;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack after request");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	a_dat_idle: assert property (p_dat_idle) else $error("data without ack");
	a_fsel: assert property (p_fsel)
		else $error("fsel write not applied");
	a_scs: assert property (p_scs)
		else $error("clock select not applied");
	a_rst_cfg: assert property (p_rst_cfg)
		else $error("wrong reset frequency");
	a_rst_scs: assert property (p_rst_scs)
		else $error("clock select not cleared");
	a_lf: assert property (p_lf)
		else $error("monitor clock not LF");
	a_sleep: assert property (p_sleep)
		else $error("sleep not entered");
	a_lf_tune: assert property (p_lf_tune)
		else $error("LF source not plain");
	c_wr: cover property (wr_ctrl);
	c_idle: cover property (o_PWR_IDLE);
	c_sleep: cover property (o_PWR_SLEEP);
endmodule

bind osc_ctrl osc_ctrl_props u_props (.I_SYS_CLK(I_SYS_CLK),
	.I_SYS_RST(I_SYS_RST), .i_WB_CYC(i_WB_CYC), .i_WB_STB(i_WB_STB),
	.i_WB_WE(i_WB_WE), .i_WB_ADR(i_WB_ADR), .i_WB_SEL(i_WB_SEL),
	.i_WB_DAT(i_WB_DAT), .o_WB_ACK(o_WB_ACK), .o_WB_DAT(o_WB_DAT),
	.i_SLEEP_EXEC(i_SLEEP_EXEC), .i_WAKE(i_WAKE),
	.o_SYS_CLK_SEL(o_SYS_CLK_SEL), .o_INT_CFG(o_INT_CFG),
	.o_WDT_CLK_SRC(o_WDT_CLK_SRC), .o_FSCM_CLK_SRC(o_FSCM_CLK_SRC),
	.o_PWR_SLEEP(o_PWR_SLEEP), .o_PWR_IDLE(o_PWR_IDLE));

//--- verilog/osc_ctrl.sv
// Internal oscillator frequency select and main clock select registers,
// with the sleep/idle decision, behind a classic Wishbone slave.
// Assumes the oscillators report ready levels from outside the clock
// domain and that the core pulses i_SLEEP_EXEC and i_WAKE on I_SYS_CLK.
// Register writes reach the clock outputs at the edge that takes them.
//
// Notes on behaviour
// - A 3-bit frequency field picks LF, MF, HF or an MF or HF postscaler tap.
// - A write to the frequency field changes the output at once.
// - Every reset sets the internal block to its 1 MHz default.
// - At code 000 the source bit and mid-low bit pick the oscillator.
// - A 31.25 kHz clock from MF or HF follows the 6-bit tune field.
// - Watchdog and fail-safe monitor always run from the LF oscillator.
// - The sleep instruction enters Sleep or Idle per the idle bit.
// - A 2-bit select picks primary, secondary or internal main clock.
// - Every reset clears the main clock select to the primary clock.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
module osc_ctrl
	import osc_pkg::*;
(
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_SYS_RST,
	// Wishbone slave
	input wire logic i_WB_CYC,
	input wire logic i_WB_STB,
	input wire logic i_WB_WE,
	input wire logic [ADR_W-1:0] i_WB_ADR,
	input wire logic [3:0] i_WB_SEL,
	input wire logic [31:0] i_WB_DAT,
	output logic o_WB_ACK,
	output logic [31:0] o_WB_DAT,
	// Oscillator ready levels, asynchronous
	input wire logic i_LF_READY,
	input wire logic i_MF_READY,
	input wire logic i_HF_READY,
	// Core power events
	input wire logic i_SLEEP_EXEC,
	input wire logic i_WAKE,
	// Clock control outputs
	output logic [1:0] o_SYS_CLK_SEL,
	output int_cfg_s o_INT_CFG,
	output logic [1:0] o_WDT_CLK_SRC,
	output logic [1:0] o_FSCM_CLK_SRC,
	// Power state
	output logic o_PWR_SLEEP,
	output logic o_PWR_IDLE
);

	// Register fields
	logic [2:0] fsel_r, fsel_nxt;
	logic [1:0] scs_r, scs_nxt;
	logic idle_en_r, idle_en_nxt;
	logic mf_low_sel_r, mf_low_sel_nxt;
	logic lf_src_sel_r, lf_src_sel_nxt;
	logic [5:0] tune_r, tune_nxt;

	// Bus state
	logic ack_r, ack_nxt;
	logic [31:0] rdat_r, rdat_nxt;
	logic req;
	logic wr;
	logic [7:0] rd_byte;
	logic hit_ctrl;
	logic hit_ctrl2;
	logic hit_tune;
	logic wr_ctrl;
	logic wr_ctrl2;
	logic wr_tune;

	// Clock control output registers
	logic [1:0] sys_sel_r, sys_sel_nxt;
	int_cfg_s cfg_r, cfg_nxt;
	int_cfg_s map_cfg;
	logic [1:0] wdt_src_r, wdt_src_nxt;
	logic [1:0] fscm_src_r, fscm_src_nxt;

	// Power state and its output flops
	pwr_e pwr_r, pwr_nxt;
	logic sleep_r, sleep_nxt;
	logic idle_r, idle_nxt;

	// Oscillator ready synchronisers
	logic [NUM_OSC-1:0] rdy_in;
	logic [NUM_OSC-1:0] rdy_r;
	logic [NUM_OSC-1:0] rdy_nxt;

	// Synchronised ready levels as software reads them
	logic lf_ok;
	logic mf_ok;
	logic hf_ok;

	assign rdy_in = {i_HF_READY, i_MF_READY, i_LF_READY};
	assign lf_ok = rdy_r[0];
	assign mf_ok = rdy_r[1];
	assign hf_ok = rdy_r[2];

	genvar g;
	generate
		for (g = 0; g < NUM_OSC; g++) begin : gen_sync
			logic [SYNC_STAGES-1:0] stg_r, stg_nxt;
			// Only stage 0 sees the raw level; stages 1 and 2 vote
			always_comb begin
				stg_nxt = {stg_r[SYNC_STAGES-2:0], rdy_in[g]};
			end
			always_ff @(posedge I_SYS_CLK) begin
				if (I_SYS_RST) begin
					stg_r <= '0;
				end else begin
					stg_r <= stg_nxt;
				end
			end
			// A change counts once the second and third stages agree
			always_comb begin
				rdy_nxt[g] = rdy_r[g];
				if (stg_r[1] == stg_r[2]) begin
					rdy_nxt[g] = stg_r[2];
				end
			end
		end
	endgenerate

	// Bus request and write strobe
	assign req = i_WB_CYC & i_WB_STB & ~ack_r;
	assign wr = req & i_WB_WE & i_WB_SEL[0];
	assign wr_ctrl = wr & hit_ctrl;
	assign wr_ctrl2 = wr & hit_ctrl2;
	assign wr_tune = wr & hit_tune;

	// Register select, shared by the write and read paths
	always_comb begin
		hit_ctrl = 1'b0;
		hit_ctrl2 = 1'b0;
		hit_tune = 1'b0;
		if (i_WB_ADR == ADR_CTRL) begin
			hit_ctrl = 1'b1;
		end else if (i_WB_ADR == ADR_CTRL2) begin
			hit_ctrl2 = 1'b1;
		end else if (i_WB_ADR == ADR_TUNING) begin
			hit_tune = 1'b1;
		end
	end

	// Register writes
	always_comb begin
		fsel_nxt = fsel_r;
		scs_nxt = scs_r;
		idle_en_nxt = idle_en_r;
		mf_low_sel_nxt = mf_low_sel_r;
		lf_src_sel_nxt = lf_src_sel_r;
		tune_nxt = tune_r;
		// Read-only status bits have no write path
		if (wr_ctrl) begin
			idle_en_nxt = i_WB_DAT[CTRL_IDLE_BIT];
			fsel_nxt = i_WB_DAT[CTRL_FSEL_LSB +: 3];
			scs_nxt = i_WB_DAT[CTRL_SCS_LSB +: 2];
		end
		if (wr_ctrl2) begin
			mf_low_sel_nxt = i_WB_DAT[CTRL2_MFSEL_BIT];
		end
		if (wr_tune) begin
			lf_src_sel_nxt = i_WB_DAT[TUNE_SRC_BIT];
			tune_nxt = i_WB_DAT[TUNE_LSB +: 6];
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			fsel_r <= FSEL_RST;
			scs_r <= SCS_RST;
			idle_en_r <= IDLE_RST;
			mf_low_sel_r <= MFSEL_RST;
			lf_src_sel_r <= LFSRC_RST;
			tune_r <= TUNE_RST;
			rdy_r <= '0;
		end else begin
			fsel_r <= fsel_nxt;
			scs_r <= scs_nxt;
			idle_en_r <= idle_en_nxt;
			mf_low_sel_r <= mf_low_sel_nxt;
			lf_src_sel_r <= lf_src_sel_nxt;
			tune_r <= tune_nxt;
			rdy_r <= rdy_nxt;
		end
	end

	// Map the incoming field values so a write acts at its own edge
	osc_freq_map u_map (
		.i_fsel(fsel_nxt),
		.i_lf_src_sel(lf_src_sel_nxt),
		.i_mf_low_sel(mf_low_sel_nxt),
		.i_tune(tune_nxt),
		.o_cfg(map_cfg)
	);

	// Clock control outputs
	always_comb begin
		cfg_nxt = map_cfg;
		sys_sel_nxt = scs_nxt;
		wdt_src_nxt = SRC_LF;
		fscm_src_nxt = SRC_LF;
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			cfg_r <= '{src: SRC_HF, postscale: PS_DIV16, tune: TUNE_RST};
			sys_sel_r <= SCS_RST;
			wdt_src_r <= SRC_LF;
			fscm_src_r <= SRC_LF;
		end else begin
			cfg_r <= cfg_nxt;
			sys_sel_r <= sys_sel_nxt;
			wdt_src_r <= wdt_src_nxt;
			fscm_src_r <= fscm_src_nxt;
		end
	end

	// Read mux
	always_comb begin
		rd_byte = 8'h00;
		if (hit_ctrl) begin
			rd_byte[CTRL_IDLE_BIT] = idle_en_r;
			rd_byte[CTRL_FSEL_LSB +: 3] = fsel_r;
			rd_byte[CTRL_INTSYS_BIT] = scs_r[1];
			rd_byte[CTRL_HFST_BIT] = hf_ok;
			rd_byte[CTRL_SCS_LSB +: 2] = scs_r;
		end else if (hit_ctrl2) begin
			rd_byte[CTRL2_MFSEL_BIT] = mf_low_sel_r;
			rd_byte[CTRL2_MFST_BIT] = mf_ok;
			rd_byte[CTRL2_LFST_BIT] = lf_ok;
		end else if (hit_tune) begin
			rd_byte[TUNE_SRC_BIT] = lf_src_sel_r;
			rd_byte[TUNE_LSB +: 6] = tune_r;
		end
	end

	// Bus answer one cycle after the request
	always_comb begin
		ack_nxt = req;
		rdat_nxt = 32'h0000_0000;
		if (req && !i_WB_WE) begin
			rdat_nxt = {24'h00_0000, rd_byte};
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end else begin
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	// Power state on the sleep instruction
	always_comb begin
		pwr_nxt = pwr_r;
		case (pwr_r)
			PWR_RUN: begin
				if (i_SLEEP_EXEC) begin
					pwr_nxt = idle_en_r ? PWR_IDLE : PWR_SLEEP;
				end
			end
			PWR_IDLE: begin
				if (i_WAKE) begin
					pwr_nxt = PWR_RUN;
				end
			end
			PWR_SLEEP: begin
				if (i_WAKE) begin
					pwr_nxt = PWR_RUN;
				end
			end
			default: begin
				pwr_nxt = PWR_RUN;
			end
		endcase
		// Output flops follow the next state so they change with it
		sleep_nxt = (pwr_nxt == PWR_SLEEP);
		idle_nxt = (pwr_nxt == PWR_IDLE);
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			pwr_r <= PWR_RUN;
			sleep_r <= 1'b0;
			idle_r <= 1'b0;
		end else begin
			pwr_r <= pwr_nxt;
			sleep_r <= sleep_nxt;
			idle_r <= idle_nxt;
		end
	end

	// Ports
	assign o_WB_ACK = ack_r;
	assign o_WB_DAT = rdat_r;
	assign o_SYS_CLK_SEL = sys_sel_r;
	assign o_INT_CFG = cfg_r;
	assign o_WDT_CLK_SRC = wdt_src_r;
	assign o_FSCM_CLK_SRC = fscm_src_r;
	assign o_PWR_SLEEP = sleep_r;
	assign o_PWR_IDLE = idle_r;

endmodule

//--- verilog/osc_freq_map.sv
// Code-to-frequency map of the internal oscillator block.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module osc_freq_map
	import osc_pkg::*;
(
	// Settings
	input wire logic [2:0] i_fsel,
	input wire logic i_lf_src_sel,
	input wire logic i_mf_low_sel,
	input wire logic [5:0] i_tune,
	// Result
	output int_cfg_s o_cfg
);

	always_comb begin
		o_cfg.src = SRC_HF;
		o_cfg.postscale = PS_DIV1;
		case (i_fsel)
			FSEL_16M: begin
				o_cfg.src = SRC_HF;
				o_cfg.postscale = PS_DIV1;
			end
			FSEL_8M: begin
				o_cfg.src = SRC_HF;
				o_cfg.postscale = PS_DIV2;
			end
			FSEL_4M: begin
				o_cfg.src = SRC_HF;
				o_cfg.postscale = PS_DIV4;
			end
			FSEL_2M: begin
				o_cfg.src = SRC_HF;
				o_cfg.postscale = PS_DIV8;
			end
			FSEL_1M: begin
				o_cfg.src = SRC_HF;
				o_cfg.postscale = PS_DIV16;
			end
			FSEL_500K: begin
				o_cfg.src = SRC_MF;
				o_cfg.postscale = PS_DIV1;
			end
			FSEL_250K: begin
				o_cfg.src = SRC_MF;
				o_cfg.postscale = PS_DIV2;
			end
			default: begin
				// 31.25 kHz source choice
				if (!i_lf_src_sel) begin
					o_cfg.src = SRC_LF;
					o_cfg.postscale = PS_DIV1;
				end else if (i_mf_low_sel) begin
					o_cfg.src = SRC_MF;
					o_cfg.postscale = PS_DIV16;
				end else begin
					o_cfg.src = SRC_HF;
					o_cfg.postscale = PS_DIV512;
				end
			end
		endcase
		// Tuning reaches only the tunable medium and high oscillators
		o_cfg.tune = (o_cfg.src == SRC_LF) ? TUNE_RST : i_tune;
	end

endmodule

//--- verilog/osc_pkg.sv
// Constants, register map and carrier types of the internal oscillator
// frequency select block.
// Assumes a 10 MHz system clock and a classic Wishbone register bus.
package osc_pkg;

	// Register indices and Wishbone byte addresses (four bytes per index)
	localparam int ADR_W = 14;
	localparam logic [11:0] IDX_TUNING = 12'hf9b;
	localparam logic [11:0] IDX_CTRL2 = 12'hfd2;
	localparam logic [11:0] IDX_CTRL = 12'hfd3;
	localparam logic [13:0] ADR_TUNING = {IDX_TUNING, 2'b00};
	localparam logic [13:0] ADR_CTRL2 = {IDX_CTRL2, 2'b00};
	localparam logic [13:0] ADR_CTRL = {IDX_CTRL, 2'b00};

	// Field positions of osc_control
	localparam int CTRL_IDLE_BIT = 7;
	localparam int CTRL_FSEL_LSB = 4;
	localparam int CTRL_INTSYS_BIT = 3;
	localparam int CTRL_HFST_BIT = 2;
	localparam int CTRL_SCS_LSB = 0;

	// Field positions of osc_control_second
	localparam int CTRL2_MFSEL_BIT = 4;
	localparam int CTRL2_MFST_BIT = 1;
	localparam int CTRL2_LFST_BIT = 0;

	// Field positions of osc_tuning
	localparam int TUNE_SRC_BIT = 7;
	localparam int TUNE_LSB = 0;

	// Reset values
	localparam logic [2:0] FSEL_RST = 3'h3;
	localparam logic [1:0] SCS_RST = 2'h0;
	localparam logic IDLE_RST = 1'b0;
	localparam logic MFSEL_RST = 1'b0;
	localparam logic LFSRC_RST = 1'b0;
	localparam logic [5:0] TUNE_RST = 6'h00;

	// Frequency select codes
	localparam logic [2:0] FSEL_31K = 3'h0;
	localparam logic [2:0] FSEL_250K = 3'h1;
	localparam logic [2:0] FSEL_500K = 3'h2;
	localparam logic [2:0] FSEL_1M = 3'h3;
	localparam logic [2:0] FSEL_2M = 3'h4;
	localparam logic [2:0] FSEL_4M = 3'h5;
	localparam logic [2:0] FSEL_8M = 3'h6;
	localparam logic [2:0] FSEL_16M = 3'h7;

	// Main clock sources
	localparam logic [1:0] SCS_PRIMARY = 2'h0;
	localparam logic [1:0] SCS_SECONDARY = 2'h1;
	localparam logic [1:0] SCS_INTERNAL = 2'h2;

	// Internal oscillator sources
	localparam logic [1:0] SRC_LF = 2'h0;
	localparam logic [1:0] SRC_MF = 2'h1;
	localparam logic [1:0] SRC_HF = 2'h2;

	// Postscaler shift: output = source >> shift
	localparam logic [3:0] PS_DIV1 = 4'h0;
	localparam logic [3:0] PS_DIV2 = 4'h1;
	localparam logic [3:0] PS_DIV4 = 4'h2;
	localparam logic [3:0] PS_DIV8 = 4'h3;
	localparam logic [3:0] PS_DIV16 = 4'h4;
	localparam logic [3:0] PS_DIV512 = 4'h9;

	// Stages of the oscillator ready synchronisers
	localparam int SYNC_STAGES = 3;
	localparam int NUM_OSC = 3;

	// Setting handed to the internal oscillator block
	typedef struct packed {
		logic [1:0] src;
		logic [3:0] postscale;
		logic [5:0] tune;
	} int_cfg_s;

	typedef enum logic [2:0] {
		PWR_RUN = 3'b001,
		PWR_IDLE = 3'b010,
		PWR_SLEEP = 3'b100
	} pwr_e;

endpackage
